// File: rtl/subch_access_pkg.sv
// Shared constants and types for the subchannel access ports.
// Assumes a framer and deframer that mark control word byte lanes.
package subch_access_pkg;

  // ************************************************************
  // Types
  // ************************************************************
  typedef logic [5:0] subch_t;
  typedef logic [7:0] bf_index_t;

  // ************************************************************
  // Hyperframe layout
  // ************************************************************
  localparam int     BYTE_W         = 8;
  localparam int     SUBCH_W        = 6;
  localparam subch_t CTRL_SUB_FIRST = 6'h04;
  localparam subch_t CTRL_SUB_LAST  = 6'h07;
  localparam subch_t VS_SUB_FIRST   = 6'h10;

  // ************************************************************
  // Reset values and buffering
  // ************************************************************
  localparam bf_index_t BF_INDEX_RST = 8'h00;
  localparam subch_t    SUBCH_RST    = 6'h00;
  localparam int        BUF_DEPTH    = 2;
  localparam logic [1:0] BUF_CNT_RST = 2'h0;
  localparam logic [1:0] BUF_CNT_FULL = 2'h2;

endpackage

// File: rtl/buf_if.sv
// Link between the frame merge stage and the two-entry word buffer.
// Assumes one clock for both ends.
`timescale 1ns/1ns
`default_nettype none
interface buf_if #(parameter int W = 32);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;
  logic [1:0]   count;

  modport store (input push_valid, push_data, pop_ready,
                 output push_ready, pop_valid, pop_data, count);
  modport user  (output push_valid, push_data, pop_ready,
                 input push_ready, pop_valid, pop_data, count);
endinterface
`default_nettype wire

// File: rtl/word_buffer.sv
// Two-entry word buffer; the head entry is a register read directly.
// Assumes synchronous active low reset on the shared clock.
`timescale 1ns/1ns
`default_nettype none
module word_buffer #(
  parameter int W = 32
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  buf_if.store      port
);
  import subch_access_pkg::*;

  logic [W-1:0] head_reg;
  logic [W-1:0] tail_reg;
  logic [1:0]   cnt_reg;
  logic [1:0]   cnt_next;
  logic         nonempty_reg;
  logic         push;
  logic         pop;

  // Valid comes from its own flop so the top output is registered
  assign port.push_ready = (cnt_reg != BUF_CNT_FULL);
  assign port.pop_valid  = nonempty_reg;
  assign cnt_next        = cnt_reg + {1'b0, push} - {1'b0, pop};
  assign port.pop_data   = head_reg;
  assign port.count      = cnt_reg;
  assign push = port.push_valid & port.push_ready;
  assign pop  = port.pop_valid & port.pop_ready;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      cnt_reg      <= BUF_CNT_RST;
      nonempty_reg <= 1'b0;
    end else begin
      cnt_reg      <= cnt_next;
      nonempty_reg <= (cnt_next != BUF_CNT_RST);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      head_reg <= '0;
      tail_reg <= '0;
    end else begin
      if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop))) begin
        head_reg <= port.push_data;
      end else if (pop && cnt_reg == BUF_CNT_FULL) begin
        head_reg <= tail_reg;
      end
      if (push && ((cnt_reg == 2'h1 && !pop) || (cnt_reg == BUF_CNT_FULL))) begin
        tail_reg <= port.push_data;
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/subch_access.sv
// Control and vendor-specific subchannel byte access ports.
// Assumes the framer marks control word lanes and gives the basic
// frame index of each word; all signals on the link-side clock.
`timescale 1ns/1ns
`default_nettype none
module subch_access #(
  parameter int DATA_W        = 32,
  parameter int WRITE_LATENCY = 1,
  parameter bit ENABLE_CTRL   = 1'b1,
  parameter bit ENABLE_VS     = 1'b1
) (
  input  wire logic                      clk_in,
  input  wire logic                      nrst_in,
  input  wire subch_access_pkg::subch_t  fast_cm_pointer_in,
  input  wire logic [DATA_W-1:0]         rx_word_in,
  input  wire logic                      rx_word_valid_in,
  input  wire logic [DATA_W/8-1:0]       rx_ctrl_lanes_in,
  input  wire subch_access_pkg::bf_index_t rx_bf_index_in,
  output logic [DATA_W/8-1:0]            control_sub_rx_byte_valid_out,
  output logic [DATA_W-1:0]              control_sub_rx_bytes_out,
  output logic [DATA_W/8-1:0]            vendor_sub_rx_byte_valid_out,
  output logic [DATA_W-1:0]              vendor_sub_rx_bytes_out,
  output subch_access_pkg::bf_index_t    rx_bf_index_out,
  input  wire logic [DATA_W-1:0]         tx_word_in,
  input  wire logic                      tx_word_valid_in,
  input  wire logic [DATA_W/8-1:0]       tx_ctrl_lanes_in,
  input  wire subch_access_pkg::bf_index_t tx_bf_index_in,
  output logic                           tx_src_ready_out,
  output subch_access_pkg::bf_index_t    tx_bf_index_out,
  output logic [DATA_W/8-1:0]            control_sub_tx_byte_ready_out,
  input  wire logic [DATA_W/8-1:0]       control_sub_tx_byte_valid_in,
  input  wire logic [DATA_W-1:0]         control_sub_tx_bytes_in,
  output logic [DATA_W/8-1:0]            vendor_sub_tx_byte_ready_out,
  input  wire logic [DATA_W/8-1:0]       vendor_sub_tx_byte_valid_in,
  input  wire logic [DATA_W-1:0]         vendor_sub_tx_bytes_in,
  output logic [DATA_W-1:0]              tx_word_out,
  output logic                           tx_word_valid_out,
  input  wire logic                      tx_word_ready_in
);
  import subch_access_pkg::*;

  localparam int LANES  = DATA_W / BYTE_W;
  localparam int STAGES = WRITE_LATENCY + 1;

  // ************************************************************
  // Subchannel decode
  // ************************************************************
  subch_t rx_sub;
  subch_t tx_sub;
  logic   rx_is_ctrl;
  logic   rx_is_vs;
  logic   tx_is_ctrl;
  logic   tx_is_vs;

  assign rx_sub = rx_bf_index_in[SUBCH_W-1:0];
  assign tx_sub = tx_bf_index_in[SUBCH_W-1:0];
  assign rx_is_ctrl = ENABLE_CTRL && rx_sub >= CTRL_SUB_FIRST
                      && rx_sub <= CTRL_SUB_LAST;
  assign tx_is_ctrl = ENABLE_CTRL && tx_sub >= CTRL_SUB_FIRST
                      && tx_sub <= CTRL_SUB_LAST;
  assign rx_is_vs = ENABLE_VS && rx_sub >= VS_SUB_FIRST
                    && rx_sub < fast_cm_pointer_in;
  assign tx_is_vs = ENABLE_VS && tx_sub >= VS_SUB_FIRST
                    && tx_sub < fast_cm_pointer_in;

  // ************************************************************
  // Receive extraction
  // ************************************************************
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      control_sub_rx_byte_valid_out <= '0;
      control_sub_rx_bytes_out      <= '0;
      vendor_sub_rx_byte_valid_out  <= '0;
      vendor_sub_rx_bytes_out       <= '0;
      rx_bf_index_out               <= BF_INDEX_RST;
    end else begin
      control_sub_rx_byte_valid_out <= (rx_word_valid_in && rx_is_ctrl)
                                       ? rx_ctrl_lanes_in : '0;
      vendor_sub_rx_byte_valid_out  <= (rx_word_valid_in && rx_is_vs)
                                       ? rx_ctrl_lanes_in : '0;
      if (rx_word_valid_in) begin
        rx_bf_index_out <= rx_bf_index_in;
      end
      // Disabled ports keep their data outputs at zero
      if (rx_word_valid_in && ENABLE_CTRL) begin
        control_sub_rx_bytes_out <= rx_word_in;
      end
      if (rx_word_valid_in && ENABLE_VS) begin
        vendor_sub_rx_bytes_out <= rx_word_in;
      end
    end
  end

  // ************************************************************
  // Transmit offer and latency pipeline
  // ************************************************************
  logic [DATA_W-1:0] st_word [STAGES];
  logic [LANES-1:0]  st_ctrl [STAGES];
  logic [LANES-1:0]  st_vs   [STAGES];
  logic [STAGES-1:0] st_v;
  logic              tx_accept;
  logic [3:0]        inflight_next;
  logic [STAGES-1:0] st_v_next;
  logic [3:0]        cnt_next;

  buf_if #(.W(DATA_W)) store_bus ();

  assign tx_accept = tx_word_valid_in & tx_src_ready_out;
  assign st_v_next = {st_v[STAGES-2:0], tx_accept};

  // Offer ready WRITE_LATENCY cycles ahead; the pipeline keeps the offered mask
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      control_sub_tx_byte_ready_out <= '0;
      vendor_sub_tx_byte_ready_out  <= '0;
      tx_bf_index_out               <= BF_INDEX_RST;
    end else begin
      control_sub_tx_byte_ready_out <= (tx_accept && tx_is_ctrl)
                                       ? tx_ctrl_lanes_in : '0;
      vendor_sub_tx_byte_ready_out  <= (tx_accept && tx_is_vs)
                                       ? tx_ctrl_lanes_in : '0;
      if (tx_accept) begin
        tx_bf_index_out <= tx_bf_index_in;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      st_v     <= '0;
      st_word[0] <= '0;
      st_ctrl[0] <= '0;
      st_vs[0]   <= '0;
    end else begin
      st_v       <= st_v_next;
      st_word[0] <= tx_word_in;
      st_ctrl[0] <= (tx_accept && tx_is_ctrl) ? tx_ctrl_lanes_in : '0;
      st_vs[0]   <= (tx_accept && tx_is_vs) ? tx_ctrl_lanes_in : '0;
    end
  end

  // Delay the offer by the write latency so data meets its slot
  for (genvar s = 1; s < STAGES; s++) begin : g_stage
    always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
        st_word[s] <= '0;
        st_ctrl[s] <= '0;
        st_vs[s]   <= '0;
      end else begin
        st_word[s] <= st_word[s-1];
        st_ctrl[s] <= st_ctrl[s-1];
        st_vs[s]   <= st_vs[s-1];
      end
    end
  end

  // ************************************************************
  // Byte insertion
  // ************************************************************
  logic [DATA_W-1:0] merged;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    logic take_ctrl;
    logic take_vs;
    assign take_ctrl = st_ctrl[STAGES-1][i]
                       & control_sub_tx_byte_valid_in[i];
    assign take_vs   = st_vs[STAGES-1][i]
                       & vendor_sub_tx_byte_valid_in[i];
    assign merged[i*BYTE_W +: BYTE_W] =
      take_ctrl ? control_sub_tx_bytes_in[i*BYTE_W +: BYTE_W] :
      take_vs   ? vendor_sub_tx_bytes_in[i*BYTE_W +: BYTE_W] :
                  st_word[STAGES-1][i*BYTE_W +: BYTE_W];
  end

  // ************************************************************
  // Output buffer and source back-pressure
  // ************************************************************
  assign store_bus.push_valid = st_v[STAGES-1];
  assign store_bus.push_data  = merged;
  assign store_bus.pop_ready  = tx_word_ready_in;

  word_buffer #(.W(DATA_W)) u_buffer (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .port    (store_bus)
  );

  // Words in flight plus stored may never exceed the two entries
  always_comb begin
    inflight_next = 4'h0;
    for (int k = 0; k < STAGES; k++) begin
      inflight_next = inflight_next + {3'h0, st_v_next[k]};
    end
    cnt_next = {2'h0, store_bus.count}
               + {3'h0, store_bus.push_valid & store_bus.push_ready};
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      tx_src_ready_out <= 1'b0;
    end else begin
      tx_src_ready_out <= (cnt_next + inflight_next) < 4'(BUF_DEPTH);
    end
  end

  assign tx_word_out       = store_bus.pop_data;
  assign tx_word_valid_out = store_bus.pop_valid;
endmodule
`default_nettype wire

// File: verification/subch_access_chk.sv
// Concurrent checks on the subchannel access top ports.
// Assumes one link-side clock and synchronous active low reset.
`timescale 1ns/1ns
`default_nettype none
module subch_access_chk #(parameter int DATA_W = 32) (
  input wire logic                clk_in,
  input wire logic                nrst_in,
  input wire logic [5:0]          fast_cm_pointer_in,
  input wire logic                rx_word_valid_in,
  input wire logic [DATA_W/8-1:0] rx_ctrl_lanes_in,
  input wire logic [7:0]          rx_bf_index_in,
  input wire logic [DATA_W/8-1:0] control_sub_rx_byte_valid_out,
  input wire logic [DATA_W/8-1:0] vendor_sub_rx_byte_valid_out,
  input wire logic [7:0]          rx_bf_index_out,
  input wire logic                tx_word_valid_in,
  input wire logic [DATA_W/8-1:0] tx_ctrl_lanes_in,
  input wire logic [7:0]          tx_bf_index_in,
  input wire logic                tx_src_ready_out,
  input wire logic [DATA_W/8-1:0] control_sub_tx_byte_ready_out,
  input wire logic [DATA_W/8-1:0] vendor_sub_tx_byte_ready_out,
  input wire logic [DATA_W-1:0]   tx_word_out,
  input wire logic                tx_word_valid_out,
  input wire logic                tx_word_ready_in
);
  import subch_access_pkg::*;
  localparam int L = DATA_W / 8;
  function automatic logic in_c(input logic [5:0] s);
    return s >= CTRL_SUB_FIRST && s <= CTRL_SUB_LAST;
  endfunction
  function automatic logic in_v(input logic [5:0] s, input logic [5:0] p);
    return s >= VS_SUB_FIRST && s < p;
  endfunction
  wire logic [5:0]   rs = rx_bf_index_in[5:0];
  wire logic [5:0]   ts = tx_bf_index_in[5:0];
  wire logic         take = tx_word_valid_in && tx_src_ready_out;
  wire logic [L-1:0] rc = in_c(rs) ? rx_ctrl_lanes_in : '0;
  wire logic [L-1:0] rv = in_v(rs, fast_cm_pointer_in) ? rx_ctrl_lanes_in : '0;
  wire logic [L-1:0] tc = in_c(ts) ? tx_ctrl_lanes_in : '0;
  wire logic [L-1:0] tv = in_v(ts, fast_cm_pointer_in) ? tx_ctrl_lanes_in : '0;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  sequence take_s;
    tx_word_valid_in && tx_src_ready_out;
  endsequence
  sequence word_out_s;
    ##[1:4] tx_word_valid_out;
  endsequence
  ctrl_rx_mask_a: assert property (rx_word_valid_in |=>
    control_sub_rx_byte_valid_out == $past(rc)) else $error("ctrl rx mask");
  vs_rx_mask_a: assert property (rx_word_valid_in |=>
    vendor_sub_rx_byte_valid_out == $past(rv)) else $error("vs rx mask");
  rx_idle_a: assert property (!rx_word_valid_in |=>
    !(|{control_sub_rx_byte_valid_out, vendor_sub_rx_byte_valid_out}))
    else $error("rx valid without word");
  rx_index_a: assert property (rx_word_valid_in |=>
    rx_bf_index_out == $past(rx_bf_index_in)) else $error("rx index");
  ctrl_tx_ready_a: assert property (take_s |=>
    control_sub_tx_byte_ready_out == $past(tc)) else $error("ctrl ready");
  vs_tx_ready_a: assert property (take_s |=>
    vendor_sub_tx_byte_ready_out == $past(tv)) else $error("vs ready");
  ready_idle_a: assert property (!take |=>
    !(|{control_sub_tx_byte_ready_out, vendor_sub_tx_byte_ready_out}))
    else $error("ready without word");
  word_out_a: assert property (take_s |-> word_out_s)
    else $error("accepted word never offered");
  out_hold_a: assert property (tx_word_valid_out && !tx_word_ready_in |=>
    tx_word_valid_out && $stable(tx_word_out)) else $error("word lost");
endmodule
bind subch_access subch_access_chk #(.DATA_W(DATA_W)) chk (.clk_in,
  .nrst_in, .fast_cm_pointer_in, .rx_word_valid_in, .rx_ctrl_lanes_in,
  .rx_bf_index_in, .control_sub_rx_byte_valid_out,
  .vendor_sub_rx_byte_valid_out, .rx_bf_index_out, .tx_word_valid_in,
  .tx_ctrl_lanes_in, .tx_bf_index_in, .tx_src_ready_out,
  .control_sub_tx_byte_ready_out, .vendor_sub_tx_byte_ready_out,
  .tx_word_out, .tx_word_valid_out, .tx_word_ready_in);
`default_nettype wire

// File: verification/subch_user_model.sv
// User mapping logic on the transmit byte ports.
// Assumes write latency one on the shared link-side clock.
`timescale 1ns/1ns
`default_nettype none
module subch_user_model #(
  parameter logic [31:0] CTRL_D = 32'hA1B2_C3D4,
  parameter logic [31:0] VS_D   = 32'h5E6F_7081
) (
  input  wire logic       clk_in,
  input  wire logic       nrst_in,
  input  wire logic       en_in,
  input  wire logic [3:0] ctrl_ready_in,
  input  wire logic [3:0] vs_ready_in,
  output logic [3:0]      ctrl_valid_out,
  output logic [31:0]     ctrl_bytes_out,
  output logic [3:0]      vs_valid_out,
  output logic [31:0]     vs_bytes_out
);
  // Valid one cycle after ready; bytes are inverted only one cycle after a cycle where no lane was offered
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ctrl_valid_out <= 4'h0;
      vs_valid_out   <= 4'h0;
    end else begin
      ctrl_valid_out <= en_in ? ctrl_ready_in : 4'h0;
      vs_valid_out   <= en_in ? vs_ready_in : 4'h0;
    end
    ctrl_bytes_out <= |ctrl_ready_in ? CTRL_D : ~CTRL_D;
    vs_bytes_out   <= |vs_ready_in ? VS_D : ~VS_D;
  end
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Self-checking bench for the subchannel access ports.
// Assumes a 50 MHz clock and a user model with write latency one.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import subch_access_pkg::*;
  localparam logic [31:0] CD = 32'hA1B2_C3D4;
  localparam logic [31:0] VD = 32'h5E6F_7081;
  logic        clk_in = 1'b0, nrst_in = 1'b0, user_en = 1'b0;
  logic        rx_word_valid_in = 1'b0, tx_word_valid_in = 1'b0;
  logic        tx_word_ready_in = 1'b0, tx_src_ready_out, tx_word_valid_out;
  logic [3:0]  rx_ctrl_lanes_in = 4'h0, tx_ctrl_lanes_in = 4'h0;
  logic [3:0]  control_sub_rx_byte_valid_out, vendor_sub_rx_byte_valid_out;
  logic [3:0]  control_sub_tx_byte_ready_out, vendor_sub_tx_byte_ready_out;
  logic [3:0]  control_sub_tx_byte_valid_in, vendor_sub_tx_byte_valid_in;
  logic [31:0] rx_word_in = 32'h0000_0000, tx_word_in = 32'h0000_0000;
  logic [31:0] control_sub_rx_bytes_out, vendor_sub_rx_bytes_out, tx_word_out;
  logic [31:0] control_sub_tx_bytes_in, vendor_sub_tx_bytes_in;
  subch_t      fast_cm_pointer_in = 6'h14;
  bf_index_t   rx_bf_index_in = 8'h00, tx_bf_index_in = 8'h00, rx_bf_index_out;
  bf_index_t   tx_bf_index_out;
  int          fail_count = 0, compares = 0, cyc = 0;
  subch_access #(.DATA_W(32), .WRITE_LATENCY(1)) uut (.clk_in, .nrst_in,
    .fast_cm_pointer_in, .rx_word_in, .rx_word_valid_in, .rx_ctrl_lanes_in,
    .rx_bf_index_in, .control_sub_rx_byte_valid_out, .control_sub_rx_bytes_out,
    .vendor_sub_rx_byte_valid_out, .vendor_sub_rx_bytes_out, .rx_bf_index_out,
    .tx_word_in, .tx_word_valid_in, .tx_ctrl_lanes_in, .tx_bf_index_in,
    .tx_src_ready_out, .tx_bf_index_out, .control_sub_tx_byte_ready_out,
    .control_sub_tx_byte_valid_in, .control_sub_tx_bytes_in,
    .vendor_sub_tx_byte_ready_out, .vendor_sub_tx_byte_valid_in,
    .vendor_sub_tx_bytes_in, .tx_word_out, .tx_word_valid_out,
    .tx_word_ready_in);
  subch_user_model #(.CTRL_D(CD), .VS_D(VD)) user (.clk_in, .nrst_in,
    .en_in(user_en), .ctrl_ready_in(control_sub_tx_byte_ready_out),
    .vs_ready_in(vendor_sub_tx_byte_ready_out),
    .ctrl_valid_out(control_sub_tx_byte_valid_in),
    .ctrl_bytes_out(control_sub_tx_bytes_in),
    .vs_valid_out(vendor_sub_tx_byte_valid_in),
    .vs_bytes_out(vendor_sub_tx_bytes_in));
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [3:0] cm(input subch_t s, input logic [3:0] l);
    return (s >= CTRL_SUB_FIRST && s <= CTRL_SUB_LAST) ? l : 4'h0;
  endfunction
  function automatic logic [3:0] vm(input subch_t s, input logic [3:0] l);
    return (s >= VS_SUB_FIRST && s < fast_cm_pointer_in) ? l : 4'h0;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] w,
    input logic [31:0] d, input logic [3:0] m);
    for (int i = 0; i < 4; i++)
      if (m[i]) w[8*i +: 8] = d[8*i +: 8];
    return w;
  endfunction
  // Back-to-back receive words across subchannel boundaries
  task automatic rx_scan();
    subch_t     s [8] = '{6'h03, 6'h04, 6'h07, 6'h08,
                          6'h0F, 6'h10, 6'h13, 6'h14};
    logic [3:0] ln [8];
    for (int i = 0; i <= 8; i++) begin
      @(posedge clk_in);
      rx_word_valid_in <= (i < 8);
      if (i < 8) begin
        ln[i] = 4'hF >> (i % 3);
        rx_word_in       <= 32'hC0DE_0000 + i;
        rx_ctrl_lanes_in <= ln[i];
        rx_bf_index_in   <= {2'b10, s[i]};
      end
      #1;
      if (i > 0) begin
        chk(control_sub_rx_byte_valid_out, cm(s[i-1], ln[i-1]));
        chk(vendor_sub_rx_byte_valid_out, vm(s[i-1], ln[i-1]));
        chk(vendor_sub_rx_bytes_out, 32'hC0DE_0000 + i - 1);
        chk(control_sub_rx_bytes_out, 32'hC0DE_0000 + i - 1);
        chk(rx_bf_index_out, {2'b10, s[i-1]});
      end
    end
  endtask
  // One framer word merged with user bytes, then popped
  task automatic tx_one(input subch_t s, input logic [3:0] l, input logic en);
    logic [31:0] w;
    w = 32'h1357_9BDF ^ {26'h0, s};
    @(posedge clk_in);
    user_en          <= en;
    tx_word_in       <= w;
    tx_ctrl_lanes_in <= l;
    tx_bf_index_in   <= {2'b00, s};
    tx_word_valid_in <= 1'b1;
    do @(posedge clk_in); while (tx_src_ready_out !== 1'b1);
    tx_word_valid_in <= 1'b0;
    if (!en)
      l = 4'h0;
    do @(posedge clk_in); while (tx_word_valid_out !== 1'b1);
    chk(tx_word_out, merge(merge(w, CD, cm(s, l)), VD, vm(s, l)));
    chk(tx_bf_index_out, {2'b00, s});
    tx_word_ready_in <= 1'b1;
    @(posedge clk_in);
    tx_word_ready_in <= 1'b0;
  endtask
  // Stalled output fills the buffer, then drains in order
  task automatic buf_fill();
    int n = 0;
    @(posedge clk_in);
    tx_ctrl_lanes_in <= 4'h0;
    tx_word_in       <= 32'hF000_0000;
    tx_word_valid_in <= 1'b1;
    repeat (20) begin
      @(posedge clk_in);
      if (tx_src_ready_out === 1'b1) begin
        n++;
        tx_word_in <= 32'hF000_0000 + n;
      end
    end
    tx_word_valid_in <= 1'b0;
    chk(n, BUF_DEPTH);
    for (int k = 0; k < BUF_DEPTH; k++) begin
      do @(posedge clk_in); while (tx_word_valid_out !== 1'b1);
      chk(tx_word_out, 32'hF000_0000 + k);
      tx_word_ready_in <= 1'b1;
      @(posedge clk_in);
      tx_word_ready_in <= 1'b0;
    end
    @(posedge clk_in);
    chk(tx_word_valid_out, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    nrst_in <= 1'b1;
    rx_scan();
    tx_one(6'h05, 4'b1000, 1'b1);
    tx_one(6'h07, 4'b1111, 1'b1);
    tx_one(6'h03, 4'b1111, 1'b1);
    tx_one(6'h10, 4'b0110, 1'b1);
    tx_one(6'h14, 4'b1111, 1'b1);
    tx_one(6'h06, 4'b1111, 1'b0);
    buf_fill();
    complete_run();
  end
endmodule
`default_nettype wire
